// file: src/adc_seq_defines.vh
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH
// Bus clock rate in kHz
`define BUS_CLK_KHZ 200000
// Highest conversion clock rate in kHz
`define CONV_CLK_MAX_KHZ 2000
// Least prescale ratio that keeps the conversion clock in range
`define PRESCALE_MIN ((`BUS_CLK_KHZ + `CONV_CLK_MAX_KHZ - 1) / `CONV_CLK_MAX_KHZ)
// Prescaler reset value, in bus cycles per conversion clock half period
`define PRESCALE_HALF_RST 7'h32
// Sample window length in conversion clock cycles
`define SAMPLE_CYCLES 4'he
// Result width and codes
`define RES_W 10
`define CODE_ZERO 10'h000
`define CODE_FULL 10'h3ff
`define CODE_FIRST 10'h001
// First trial value and its bit index at the start of approximation
`define CODE_MSB_TRIAL 10'h200
`define SAR_MSB_IDX 4'h9
// Channel select codes for the two reference conversions
`define CH_REF_LOW 4'h8
`define CH_REF_HIGH 4'h9
// Control reset values
`define CTRL_RST 1'b0
`define CH_RST 4'h0
`endif

// file: src/sar_step.v
`include "adc_seq_defines.vh"
// ************************************************************
// Successive approximation step
// ************************************************************
module sar_step (
  input wire [9:0] sar_val,
  input wire [3:0] bit_idx,
  input wire comp_high,
  output reg [9:0] sar_out
);
  // Keep or drop the trial bit, then set the next lower trial bit
  always @*
  begin
    sar_out = sar_val;
    if (!comp_high)
      sar_out[bit_idx] = 1'b0;
    if (bit_idx != 4'h0)
      sar_out[bit_idx - 4'h1] = 1'b1;
  end
endmodule

// file: src/sar_adc_sequence_reset_control.v
`include "adc_seq_defines.vh"
module sar_adc_sequence_reset_control (
  input wire clk,
  input wire rst_b,
  input wire ctrl_wr,
  input wire ctrl_power_on,
  input wire [6:0] ctrl_prescale_half,
  input wire stat_wr,
  input wire [3:0] stat_channel,
  input wire stat_int_en,
  input wire result_high_rd,
  input wire result_low_rd,
  input wire comp_in,
  output reg converter_power_on,
  output reg conversion_clk,
  output reg sample_clk_en,
  output reg sar_active,
  output reg [7:0] channel_sel,
  output reg ref_low_sel,
  output reg ref_high_sel,
  output reg [9:0] sar_reg,
  output reg [9:0] result_reg,
  output reg conversion_done_flag,
  output reg irq_req
);
  // ************************************************************
  // State encoding
  // ************************************************************
  localparam ST_IDLE = 3'b001;
  localparam ST_SAMPLE = 3'b010;
  localparam ST_CONVERT = 3'b100;
  // Least half period that keeps the conversion clock in range
  localparam integer PRESC_HALF_MIN_I = `PRESCALE_MIN / 2;
  localparam [6:0] PRESC_HALF_MIN = PRESC_HALF_MIN_I[6:0];

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [6:0] presc_cnt_reg;
  reg [6:0] presc_half_reg;
  reg [3:0] chan_reg;
  reg int_en_reg;
  reg [3:0] samp_cnt_reg;
  reg [3:0] bit_idx_reg;
  reg comp_s1_reg;
  reg comp_s2_reg;
  reg conv_tick;
  wire [9:0] sar_stepped;
  wire start_conv;
  wire abort_conv;
  wire is_ref;
  wire [3:0] chan_next;

  // Compare level from the analog comparator, synchronised
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      comp_s1_reg <= 1'b0;
      comp_s2_reg <= 1'b0;
    end
    else
    begin
      comp_s1_reg <= comp_in;
      comp_s2_reg <= comp_s1_reg;
    end
  end

  // Decode a reference conversion channel
  function is_ref_ch;
    input [3:0] ch;
    begin
      is_ref_ch = (ch == `CH_REF_LOW) || (ch == `CH_REF_HIGH);
    end
  endfunction

  assign start_conv = stat_wr && converter_power_on;
  assign abort_conv = ctrl_wr || !converter_power_on;
  assign is_ref = is_ref_ch(chan_reg);
  // Channel in force from the start cycle on, so routing never shows a stale one
  assign chan_next = stat_wr ? stat_channel : chan_reg;

  // ************************************************************
  // Control registers
  // ************************************************************
  // Power-on bit, prescaler, channel and interrupt enable; set by reset and by register writes
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      converter_power_on <= `CTRL_RST;
      presc_half_reg <= `PRESCALE_HALF_RST;
      chan_reg <= `CH_RST;
      int_en_reg <= `CTRL_RST;
    end
    else
    begin
      // Writes only store fields here; ctrl_wr also aborts the conversion and stat_wr starts one when powered
      if (ctrl_wr)
      begin
        converter_power_on <= ctrl_power_on;
        if (ctrl_prescale_half >= PRESC_HALF_MIN)
          presc_half_reg <= ctrl_prescale_half;
      end
      if (stat_wr)
      begin
        chan_reg <= stat_channel;
        int_en_reg <= stat_int_en;
      end
    end
  end

  // ************************************************************
  // Conversion clock prescaler
  // ************************************************************
  // Divides the bus clock; held still while powered down
  always @(posedge clk)
  begin
    if (!rst_b || !converter_power_on)
    begin
      presc_cnt_reg <= 7'h00;
      conversion_clk <= 1'b0;
      conv_tick <= 1'b0;
    end
    else if (presc_cnt_reg + 7'h01 >= presc_half_reg)
    begin
      presc_cnt_reg <= 7'h00;
      conversion_clk <= !conversion_clk;
      conv_tick <= !conversion_clk; // Rising edge of conversion clock
    end
    else
    begin
      presc_cnt_reg <= presc_cnt_reg + 7'h01;
      conv_tick <= 1'b0;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  // Next state
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (start_conv)
          state_next = is_ref_ch(stat_channel) ? ST_CONVERT : ST_SAMPLE;
      ST_SAMPLE:
        if (conv_tick && samp_cnt_reg == `SAMPLE_CYCLES - 4'h1)
          state_next = ST_CONVERT;
      ST_CONVERT:
        if (conv_tick && bit_idx_reg == 4'h0)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
    if (abort_conv)
      state_next = ST_IDLE;
    else if (start_conv)
      state_next = is_ref_ch(stat_channel) ? ST_CONVERT : ST_SAMPLE;
  end

  sar_step u_step (
    .sar_val(sar_reg),
    .bit_idx(bit_idx_reg),
    .comp_high(comp_s2_reg),
    .sar_out(sar_stepped)
  );

  // State, counters, SAR and result
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      samp_cnt_reg <= 4'h0;
      bit_idx_reg <= 4'h0;
      sar_reg <= `CODE_ZERO;
      result_reg <= `CODE_ZERO;
      conversion_done_flag <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == ST_SAMPLE && conv_tick)
        samp_cnt_reg <= samp_cnt_reg + 4'h1;
      if (start_conv && !abort_conv)
      begin
        samp_cnt_reg <= 4'h0;
        bit_idx_reg <= `SAR_MSB_IDX;
        // MSB trial first; references load their level directly
        if (stat_channel == `CH_REF_LOW)
          sar_reg <= `CODE_ZERO;
        else if (stat_channel == `CH_REF_HIGH)
          sar_reg <= `CODE_FULL;
        else
          sar_reg <= `CODE_MSB_TRIAL;
      end
      else if (state_reg == ST_CONVERT && conv_tick && !abort_conv)
      begin
        if (!is_ref)
          sar_reg <= sar_stepped;
        if (bit_idx_reg == 4'h0)
        begin
          result_reg <= is_ref ? sar_reg : sar_stepped;
          conversion_done_flag <= 1'b1;
        end
        else
          bit_idx_reg <= bit_idx_reg - 4'h1;
      end
      // Completion wins over a simultaneous clear
      if ((stat_wr || result_high_rd || result_low_rd) &&
          !(state_reg == ST_CONVERT && conv_tick && bit_idx_reg == 4'h0 && !abort_conv))
        conversion_done_flag <= 1'b0;
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  // Stage enables, channel routing and interrupt
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      sample_clk_en <= 1'b0;
      sar_active <= 1'b0;
      channel_sel <= 8'h00;
      ref_low_sel <= 1'b0;
      ref_high_sel <= 1'b0;
      irq_req <= 1'b0;
    end
    else
    begin
      sample_clk_en <= (state_next == ST_SAMPLE);
      sar_active <= (state_next == ST_CONVERT);
      channel_sel <= (state_next == ST_SAMPLE) ? (8'h01 << chan_next[2:0]) : 8'h00;
      ref_low_sel <= (state_next == ST_CONVERT) && (chan_next == `CH_REF_LOW);
      ref_high_sel <= (state_next == ST_CONVERT) && (chan_next == `CH_REF_HIGH);
      irq_req <= conversion_done_flag && int_en_reg;
    end
  end
endmodule

// file: test/sar_adc_seq_asserts.sv
// ****************************************
// Sequencing checks at the block ports
// ****************************************
module sar_adc_seq_asserts (
  input logic clk,
  input logic rst_b,
  input logic ctrl_wr,
  input logic stat_wr,
  input logic [3:0] stat_channel,
  input logic converter_power_on,
  input logic conversion_clk,
  input logic sample_clk_en,
  input logic sar_active,
  input logic [7:0] channel_sel,
  input logic ref_low_sel,
  input logic ref_high_sel,
  input logic [9:0] sar_reg,
  input logic conversion_done_flag,
  input logic irq_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic cc_q;
  logic [4:0] ticks;
  // Counts conversion clock rises inside one sample window
  always_ff @(posedge clk)
  begin
    cc_q <= conversion_clk;
    ticks <= (!sample_clk_en || stat_wr) ? 5'h00 : ticks + {4'h0, conversion_clk & ~cc_q};
  end
  a_single_sample: assert property (!(sample_clk_en && sar_active))
    else $error("sampling and SAR active together");
  a_sample_gated: assert property (!sample_clk_en |-> channel_sel == 8'h00)
    else $error("channel routed outside sample window");
  a_window_len: assert property ($fell(sample_clk_en) && sar_active && !$past(stat_wr)
    |-> ticks == 5'h0e)
    else $error("sample window length wrong");
  a_ref_bypass: assert property (ref_low_sel || ref_high_sel |-> !sample_clk_en)
    else $error("reference conversion used sampler");
  a_one_channel: assert property (sample_clk_en |-> $onehot(channel_sel))
    else $error("channel select not one-hot");
  a_reset_clear: assert property (disable iff (1'b0) !rst_b |=> !converter_power_on
    && !conversion_done_flag && sar_reg == 10'h000 && !irq_req)
    else $error("reset left state behind");
  a_ctrl_abort: assert property (ctrl_wr |=> !sample_clk_en && !sar_active)
    else $error("control write did not abort");
  a_stat_start: assert property (stat_wr && converter_power_on && !ctrl_wr
    && stat_channel < 4'h8 |=> sample_clk_en)
    else $error("status write did not start sampling");
  a_power_off: assert property (!converter_power_on |=> !conversion_clk && !sar_active)
    else $error("activity while powered down");
  a_done_clear: assert property (stat_wr && !sar_active |=> !conversion_done_flag)
    else $error("done flag not cleared");
endmodule
bind sar_adc_sequence_reset_control sar_adc_seq_asserts u_chk (
  .clk(clk),
  .rst_b(rst_b),
  .ctrl_wr(ctrl_wr),
  .stat_wr(stat_wr),
  .stat_channel(stat_channel),
  .converter_power_on(converter_power_on),
  .conversion_clk(conversion_clk),
  .sample_clk_en(sample_clk_en),
  .sar_active(sar_active),
  .channel_sel(channel_sel),
  .ref_low_sel(ref_low_sel),
  .ref_high_sel(ref_high_sel),
  .sar_reg(sar_reg),
  .conversion_done_flag(conversion_done_flag),
  .irq_req(irq_req)
);

// file: test/sar_adc_sequence_reset_control_tb.sv
module sar_adc_sequence_reset_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, ctrl_wr = 1'b0, ctrl_power_on = 1'b0, stat_wr = 1'b0;
  logic stat_int_en = 1'b0, result_high_rd = 1'b0, result_low_rd = 1'b0, comp_in = 1'b0;
  logic [6:0] ctrl_prescale_half = 7'h32;
  logic [3:0] stat_channel = 4'h0;
  logic converter_power_on, conversion_clk, sample_clk_en, sar_active, ref_low_sel;
  logic ref_high_sel, conversion_done_flag, irq_req;
  logic [7:0] channel_sel;
  logic [9:0] sar_reg, result_reg;
  int n_errors = 0, checks = 0, cycles = 0;
  sar_adc_sequence_reset_control u_dut (.clk(clk), .rst_b(rst_b), .ctrl_wr(ctrl_wr),
    .ctrl_power_on(ctrl_power_on), .ctrl_prescale_half(ctrl_prescale_half),
    .stat_wr(stat_wr), .stat_channel(stat_channel), .stat_int_en(stat_int_en),
    .result_high_rd(result_high_rd), .result_low_rd(result_low_rd), .comp_in(comp_in),
    .converter_power_on(converter_power_on), .conversion_clk(conversion_clk),
    .sample_clk_en(sample_clk_en), .sar_active(sar_active), .channel_sel(channel_sel),
    .ref_low_sel(ref_low_sel), .ref_high_sel(ref_high_sel), .sar_reg(sar_reg),
    .result_reg(result_reg), .conversion_done_flag(conversion_done_flag), .irq_req(irq_req));
  // Bus clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    cyc(3);
    rst_b = 1'b1;
  endtask
  task automatic wr_ctrl(input logic pwr);
    ctrl_power_on = pwr;
    ctrl_wr = 1'b1;
    cyc(1);
    ctrl_wr = 1'b0;
  endtask
  task automatic wr_stat(input logic [3:0] ch, input logic ie);
    stat_channel = ch;
    stat_int_en = ie;
    stat_wr = 1'b1;
    cyc(1);
    stat_wr = 1'b0;
  endtask
  task automatic wait_done();
    int i;
    i = 0;
    while (conversion_done_flag !== 1'b1 && i < 4000)
    begin
      cyc(1);
      i++;
    end
    chk("done", 10'h001, {9'h000, conversion_done_flag});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_channels();
    wr_ctrl(1'b1);
    for (int ch = 0; ch < 10; ch++)
    begin
      comp_in = ch[0];
      wr_stat(ch[3:0], 1'b0);
      cyc(3);
      chk("done clear", 10'h000, {9'h000, conversion_done_flag});
      if (ch < 8)
        chk("channel", {2'h0, 8'h01 << ch}, {2'h0, channel_sel});
      else
        chk("ref path", 10'h001, {9'h000, (ch[0] ? ref_high_sel : ref_low_sel) & ~sample_clk_en});
      wait_done();
      chk("result", ch[0] ? 10'h3ff : 10'h000, result_reg);
    end
    $display("test channels done");
  endtask
  task automatic t_aborts();
    wr_stat(4'h5, 1'b0);
    cyc(500);
    wr_ctrl(1'b1);
    cyc(3000);
    chk("ctrl abort", 10'h000, {9'h000, conversion_done_flag});
    chk("kept result", 10'h3ff, result_reg);
    comp_in = 1'b1;
    wr_stat(4'h4, 1'b0);
    cyc(1700);
    wr_stat(4'h3, 1'b0);
    cyc(3);
    chk("restart", 10'h008, {2'h0, channel_sel});
    wait_done();
    result_high_rd = 1'b1;
    cyc(1);
    result_high_rd = 1'b0;
    cyc(1);
    chk("read clear", 10'h000, {9'h000, conversion_done_flag});
    wr_stat(4'h1, 1'b0);
    cyc(500);
    wr_ctrl(1'b0);
    cyc(3);
    chk("power off", 10'h000, {7'h00, converter_power_on, conversion_clk, sample_clk_en});
    wr_stat(4'h1, 1'b0);
    cyc(3);
    chk("ignored start", 10'h000, {9'h000, sample_clk_en});
    wr_ctrl(1'b1);
    cyc(2);
    chk("power on keeps", 10'h3ff, result_reg);
    $display("test aborts done");
  endtask
  // Comparator follows the trial value against a fixed input code
  task automatic t_code(input logic [9:0] target);
    int i;
    i = 0;
    wr_stat(4'h2, 1'b0);
    while (conversion_done_flag !== 1'b1 && i < 4000)
    begin
      comp_in = (sar_reg <= target);
      cyc(1);
      i++;
    end
    chk("code done", 10'h001, {9'h000, conversion_done_flag});
    chk("code", target, result_reg);
    $display("test code %h done", target);
  endtask
  task automatic t_resets();
    wr_stat(4'h6, 1'b1);
    wait_done();
    cyc(2);
    chk("irq", 10'h001, {9'h000, irq_req});
    do_reset();
    chk("reset state", 10'h000, {7'h00, irq_req, conversion_done_flag, converter_power_on});
    chk("reset result", 10'h000, result_reg);
    wr_ctrl(1'b1);
    wr_stat(4'h7, 1'b0);
    cyc(1800);
    chk("in sar", 10'h001, {9'h000, sar_active});
    do_reset();
    chk("sar cleared", 10'h000, sar_reg);
    $display("test resets done");
  endtask
  // Main sequence
  initial
  begin
    cyc(3);
    rst_b = 1'b1;
    chk("reset outputs", 10'h000, {8'h00, converter_power_on, conversion_clk});
    t_channels();
    t_aborts();
    t_code(10'h001);
    t_code(10'h2a5);
    t_resets();
    give_verdict();
  end
endmodule
